// >>> common/cls_pkg.sv
package cls_pkg;
  // register port widths
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [9:0] ADDR_CONV_EN = 10'h209;
  localparam logic [9:0] ADDR_SH_CFG = 10'h20f;
  localparam logic [9:0] ADDR_LINK_CTRL = 10'h200;
  localparam logic [9:0] ADDR_LANE_CFG = 10'h201;
  localparam logic [9:0] ADDR_STATUS = 10'h202;
  // converter enable register fields
  localparam int unsigned CE_FIRST_BIT = 0;
  localparam int unsigned CE_SECOND_BIT = 1;
  localparam int unsigned CE_SINGLE_BIT = 2;
  localparam logic [2:0] CE_RESET = 3'h3;
  // sync header select codes
  localparam logic [1:0] SH_RESET = 2'h0;
  localparam logic [1:0] SH_CRC = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
  // link control fields: bit 0 link enable, bits 5:1 link mode
  localparam int unsigned LC_EN_BIT = 0;
  localparam int unsigned LC_MODE_LSB = 1;
  localparam logic [4:0] LMODE_RESET = 5'h00;
  // link modes from this code upward use 64b/66b encoding
  localparam logic [4:0] LMODE_66_MIN = 5'h10;
  // base lane count of the selected mode, reset value
  localparam logic [3:0] LANES_RESET = 4'h8;
  // converter counts
  localparam logic [2:0] MX_BASE = 3'h4;
  localparam logic [2:0] M_SINGLE = 3'h1;
  // sample stream shape
  localparam int unsigned SMP_W = 12;
  localparam int unsigned CH_N = 4;
  localparam int unsigned FRM_W = SMP_W * CH_N;
  localparam int unsigned FIFO_DEPTH = 16;
  // width of the idle command field of the sync word
  localparam int unsigned CMD_W = 8;

  // true when the link mode picks 64b/66b encoding
  function automatic logic cls_enc_is_66(input logic [4:0] mode);
    return mode >= LMODE_66_MIN;
  endfunction : cls_enc_is_66
endpackage : cls_pkg

// >>> rtl/cls_fifo.sv
`timescale 1ns/1ns
module cls_fifo
  import cls_pkg::*;
#(
  parameter int unsigned WIDTH = FRM_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);

  // pointer wrap relies on a power of two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cls_fifo depth must be a power of two, at least 2");
  end

  // whole fifo state, read data leaves through a register
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
    logic [PW-1:0] wp; // write pointer
    logic [PW-1:0] rp; // read pointer
    logic [PW:0] cnt; // words held in storage
    logic room; // registered flag: storage can take a word
    logic ov; // output register holds a word
    logic [WIDTH-1:0] od; // output register
  } cls_fifo_s;

  cls_fifo_s st_reg;
  cls_fifo_s st_next;

  // push, refill of the output stage and occupancy
  always_comb begin
    logic push;
    logic take;
    logic pop;
    push = in_valid & st_reg.room;
    take = ~st_reg.ov | out_ready;
    pop = take & (st_reg.cnt != '0);
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = PW'(st_reg.wp + 1'b1);
    end
    if (pop) begin
      st_next.od = st_reg.mem[st_reg.rp];
      st_next.rp = PW'(st_reg.rp + 1'b1);
      st_next.ov = 1'b1;
    end else if (take) begin
      st_next.ov = 1'b0;
    end
    if (push && !pop) begin
      st_next.cnt = (PW + 1)'(st_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      st_next.cnt = (PW + 1)'(st_reg.cnt - 1'b1);
    end
    // room is registered so in_ready never depends on out_ready
    st_next.room = (st_next.cnt != (PW + 1)'(DEPTH));
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.room <= 1'b1; // empty storage takes words at once
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = st_reg.room;
  assign out_valid = st_reg.ov;
  assign out_data = st_reg.od;
endmodule : cls_fifo

// >>> rtl/cls_config_framer.sv
`timescale 1ns/1ns
module cls_config_framer
  import cls_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic smp_valid,
  input wire logic [FRM_W-1:0] smp_data,
  output logic smp_ready,
  output logic frm_valid,
  output logic [FRM_W-1:0] frm_data,
  input wire logic frm_ready,
  output logic [CH_N-1:0] chan_en,
  output logic [2:0] conv_count,
  output logic [3:0] lane_count,
  output logic tail_pad,
  output logic sh_crc_sel,
  output logic sh_fec_sel,
  output logic [CMD_W-1:0] sh_cmd
);
  // the frame register needs the fifo output to be registered too
  if (DEPTH < 2) begin : g_bad_depth
    $error("cls_config_framer fifo depth must be at least 2");
  end

  // all block state in one record
  typedef struct packed {
    logic [2:0] conv_en; // single, second pair, first pair
    logic [1:0] sh_sel; // sync header select field
    logic link_en; // serial link enable
    logic [4:0] lmode; // link mode select
    logic [3:0] lanes_base; // lane count of the mode
    logic [DATA_W-1:0] rdata; // read answer
    logic [CH_N-1:0] chan_en; // active channels D..A
    logic [2:0] conv_cnt; // converters in the frame
    logic [3:0] lane_cnt; // lanes in use
    logic tail_pad; // pad the highest lane
    logic sh_crc; // sync word carries CRC-12
    logic sh_fec; // sync word carries FEC
    logic [CMD_W-1:0] sh_cmd; // command field, always idle
    logic frm_valid; // frame register full
    logic [FRM_W-1:0] frm_data; // frame register
  } cls_top_s;

  cls_top_s st_reg;
  cls_top_s st_next;

  // fifo ports
  logic f_valid;
  logic [FRM_W-1:0] f_data;
  logic f_rdy;

  // exactly one pair disabled, outside single mode
  function automatic logic cls_half(input logic [2:0] ce);
    return (ce[CE_FIRST_BIT] ^ ce[CE_SECOND_BIT]) & ~ce[CE_SINGLE_BIT];
  endfunction : cls_half

  // which channels run for a given enable setting
  function automatic logic [CH_N-1:0] cls_chans(input logic [2:0] ce);
    logic a;
    logic cd;
    a = ce[CE_FIRST_BIT];
    cd = ce[CE_SECOND_BIT] & ~ce[CE_SINGLE_BIT];
    // single mode keeps only A alive
    // first pair bit gates A and B
    // second pair bit gates C and D
    return {cd, cd, a & ~ce[CE_SINGLE_BIT], a};
  endfunction : cls_chans

  // place enabled samples into frame slots, slot 0 lowest
  function automatic logic [FRM_W-1:0] cls_remap(
    input logic [FRM_W-1:0] d,
    input logic [2:0] ce
  );
    logic [FRM_W-1:0] r;
    r = '0;
    if (ce[CE_SINGLE_BIT]) begin
      // only channel A travels
      r[SMP_W-1:0] = d[SMP_W-1:0];
    end else if (!ce[CE_FIRST_BIT] && ce[CE_SECOND_BIT]) begin
      // C and D move down into the A and B slots
      r[2*SMP_W-1:0] = d[FRM_W-1:2*SMP_W];
    end else if (ce[CE_FIRST_BIT] && !ce[CE_SECOND_BIT]) begin
      r[2*SMP_W-1:0] = d[2*SMP_W-1:0];
    end else if (ce[CE_FIRST_BIT]) begin
      r = d;
    end
    // both pairs off is undefined, the frame stays empty
    return r;
  endfunction : cls_remap

  // the link side may only draw while the link runs
  assign f_rdy = st_reg.link_en & (~st_reg.frm_valid | frm_ready);

  // sample buffer between the converters and the framer
  cls_fifo #(
    .WIDTH(FRM_W),
    .DEPTH(DEPTH)
  ) i_cls_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_data(smp_data),
    .in_ready(smp_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_rdy)
  );

  // register access, derived link shape and frame stage
  always_comb begin
    logic half;
    logic is66;
    half = cls_half(st_reg.conv_en);
    is66 = cls_enc_is_66(st_reg.lmode);
    st_next = st_reg;
    // register writes keep only defined bits
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONV_EN: begin
          st_next.conv_en = reg_wdata[2:0];
        end
        ADDR_SH_CFG: begin
          st_next.sh_sel = reg_wdata[1:0];
        end
        ADDR_LINK_CTRL: begin
          st_next.link_en = reg_wdata[LC_EN_BIT];
          st_next.lmode = reg_wdata[LC_MODE_LSB+:5];
        end
        ADDR_LANE_CFG: begin
          st_next.lanes_base = reg_wdata[3:0];
        end
        default: begin
          // unmapped or read-only offsets ignore writes
        end
      endcase
    end
    // read answer stands for one cycle only
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONV_EN: begin
          st_next.rdata = {5'h00, st_reg.conv_en};
        end
        ADDR_SH_CFG: begin
          st_next.rdata = {6'h00, st_reg.sh_sel};
        end
        ADDR_LINK_CTRL: begin
          st_next.rdata = {2'h0, st_reg.lmode, st_reg.link_en};
        end
        ADDR_LANE_CFG: begin
          st_next.rdata = {4'h0, st_reg.lanes_base};
        end
        ADDR_STATUS: begin
          st_next.rdata = {st_reg.tail_pad, st_reg.conv_cnt, st_reg.lane_cnt};
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
    // channel enables follow the pair and single bits
    st_next.chan_en = cls_chans(st_reg.conv_en);
    // converter count halves with one pair off
    if (st_reg.conv_en[CE_SINGLE_BIT]) begin
      st_next.conv_cnt = M_SINGLE;
    end else if (half) begin
      st_next.conv_cnt = MX_BASE >> 1;
    end else if (st_reg.conv_en[CE_FIRST_BIT]) begin
      st_next.conv_cnt = MX_BASE;
    end else begin
      st_next.conv_cnt = '0;
    end
    // lanes halve rounding up, odd base needs tail bits
    if (half) begin
      st_next.lane_cnt = 4'((5'(st_reg.lanes_base) + 5'h01) >> 1);
      st_next.tail_pad = st_reg.lanes_base[0];
    end else begin
      st_next.lane_cnt = st_reg.lanes_base;
      st_next.tail_pad = 1'b0;
    end
    // sync header content, only for 64b/66b modes
    // reserved codes fall back to CRC so the link keeps a check
    st_next.sh_fec = is66 & (st_reg.sh_sel == SH_FEC);
    st_next.sh_crc = is66 & (st_reg.sh_sel != SH_FEC);
    // no command channel, headers stay idle
    st_next.sh_cmd = '0;
    // frame stage: refill when empty or drained, only while the link runs
    if (f_rdy) begin
      st_next.frm_valid = f_valid;
      if (f_valid) begin
        st_next.frm_data = cls_remap(f_data, st_reg.conv_en);
      end
    end else if (frm_ready) begin
      st_next.frm_valid = 1'b0;
    end
  end

  // state register with documented reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.conv_en <= CE_RESET;
      st_reg.sh_sel <= SH_RESET;
      st_reg.lmode <= LMODE_RESET;
      st_reg.lanes_base <= LANES_RESET;
      st_reg.chan_en <= {CH_N{1'b1}};
      st_reg.conv_cnt <= MX_BASE;
      st_reg.lane_cnt <= LANES_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign frm_valid = st_reg.frm_valid;
  assign frm_data = st_reg.frm_data;
  assign chan_en = st_reg.chan_en;
  assign conv_count = st_reg.conv_cnt;
  assign lane_count = st_reg.lane_cnt;
  assign tail_pad = st_reg.tail_pad;
  assign sh_crc_sel = st_reg.sh_crc;
  assign sh_fec_sel = st_reg.sh_fec;
  assign sh_cmd = st_reg.sh_cmd;

  // checks, all on the one clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a converter enable write followed by a quiet cycle
  sequence s_conv_wr;
    reg_wr && reg_addr == ADDR_CONV_EN ##1 !(reg_wr && reg_addr == ADDR_CONV_EN);
  endsequence

  // a frame word leaves the fifo into the frame register
  sequence s_frm_load;
    f_valid && f_rdy;
  endsequence

  AST_SINGLE_ONLY_A: assert property (
    st_reg.conv_en[CE_SINGLE_BIT] |=> chan_en[3:1] == 3'h0)
    else $error("single mode left B, C or D enabled");

  AST_CD_OFF: assert property (
    (reg_wdata[CE_SECOND_BIT] == 1'b0) ##0 s_conv_wr |=> chan_en[3:2] == 2'h0)
    else $error("C and D stayed on after clearing second pair");

  AST_AB_FOLLOW: assert property (
    (reg_wr && reg_addr == ADDR_CONV_EN) ##1 1'b1 |=>
      chan_en[0] == $past(reg_wdata[CE_FIRST_BIT], 2))
    else $error("channel A does not follow first pair bit");

  AST_HALF_LANES: assert property (
    cls_half(st_reg.conv_en) |=>
      lane_count == 4'((5'($past(st_reg.lanes_base)) + 5'h01) >> 1)
      && conv_count == (MX_BASE >> 1))
    else $error("halved lane or converter count wrong");

  AST_TAIL_PAD: assert property (
    ##1 tail_pad == $past(cls_half(st_reg.conv_en) & st_reg.lanes_base[0]))
    else $error("tail pad flag wrong");

  AST_REMAP_CD: assert property (
    s_frm_load ##0 (st_reg.conv_en == 3'h2) |=>
      frm_valid && frm_data[2*SMP_W-1:0] == $past(f_data[FRM_W-1:2*SMP_W])
      && frm_data[FRM_W-1:2*SMP_W] == '0)
    else $error("C and D not moved into A and B slots");

  AST_SH_FEC: assert property (
    (cls_enc_is_66(st_reg.lmode) && st_reg.sh_sel == SH_FEC) [*2] |->
      sh_fec_sel && !sh_crc_sel)
    else $error("FEC not selected for code 2");

  AST_SH_8B10B: assert property (
    !cls_enc_is_66(st_reg.lmode) |=> !sh_fec_sel && !sh_crc_sel)
    else $error("sync header select acted in 8b/10b mode");

  AST_CMD_IDLE: assert property (
    sh_cmd == '0 && $stable(sh_cmd))
    else $error("command field not idle");

  AST_READ_ONE_CYCLE: assert property (
    reg_rd && reg_addr == ADDR_CONV_EN |=>
      reg_rdata == {5'h00, $past(st_reg.conv_en)} ##1 ($past(reg_rd) || reg_rdata == '0))
    else $error("read answer late or lingering");

  // a frame word loads while single mode is set
  sequence s_single_load;
    s_frm_load ##0 st_reg.conv_en[CE_SINGLE_BIT];
  endsequence

  AST_CD_ON: assert property (
    st_reg.conv_en[CE_SECOND_BIT] && !st_reg.conv_en[CE_SINGLE_BIT] |=>
      chan_en[3:2] == 2'h3)
    else $error("C and D not running with second pair set");

  AST_FULL_SHAPE: assert property (
    st_reg.conv_en == CE_RESET |=>
      chan_en == {CH_N{1'b1}} && conv_count == MX_BASE
      && lane_count == $past(st_reg.lanes_base) && !tail_pad)
    else $error("both pairs on but frame shape reduced");

  AST_REMAP_AB: assert property (
    s_frm_load ##0 (st_reg.conv_en == 3'h1) |=>
      frm_valid && frm_data[2*SMP_W-1:0] == $past(f_data[2*SMP_W-1:0])
      && frm_data[FRM_W-1:2*SMP_W] == '0)
    else $error("A and B not kept in the low slots");

  AST_SINGLE_SLOT: assert property (
    s_single_load |=>
      frm_valid && frm_data[SMP_W-1:0] == $past(f_data[SMP_W-1:0])
      && frm_data[FRM_W-1:SMP_W] == '0)
    else $error("single mode frame carries more than channel A");

  AST_SH_CRC: assert property (
    (cls_enc_is_66(st_reg.lmode) && st_reg.sh_sel == SH_CRC) [*2] |->
      sh_crc_sel && !sh_fec_sel)
    else $error("CRC-12 not selected for code 0");

  AST_NO_TAIL_FULL: assert property (
    !cls_half(st_reg.conv_en) |=> !tail_pad)
    else $error("tail bits added with no pair disabled");

  // a frame word waiting for the link keeps its value
  AST_FRAME_HOLD: assert property (
    frm_valid && !frm_ready |=> frm_valid && $stable(frm_data))
    else $error("frame word dropped or changed before it was taken");
endmodule : cls_config_framer

// >>> tb/cls_rx_model.sv
`timescale 1ns/1ns
module cls_rx_model
  import cls_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic frm_valid,
  input wire logic [FRM_W-1:0] frm_data,
  output logic frm_ready
);
  // frame words taken from the link, in arrival order
  logic [FRM_W-1:0] q[$];
  // phase bit that throttles acceptance in slow mode
  logic ph_reg;

  // a receiver takes a word on every edge with valid and ready;
  // slow mode stalls every other cycle to exercise back-pressure
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 1'b0;
      frm_ready <= 1'b0;
    end else begin
      if (frm_valid && frm_ready) begin
        q.push_back(frm_data);
      end
      ph_reg <= ~ph_reg;
      frm_ready <= !slow || ph_reg;
    end
  end
endmodule : cls_rx_model

// >>> tb/converter_lane_enable_sync_header_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module converter_lane_enable_sync_header_tb;
  import cls_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, smp_valid, frm_valid, frm_ready, slow;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [FRM_W-1:0] smp_data, frm_data;
  logic smp_ready, tail_pad, sh_crc_sel, sh_fec_sel;
  logic [CH_N-1:0] chan_en;
  logic [2:0] conv_count;
  logic [3:0] lane_count;
  logic [CMD_W-1:0] sh_cmd;
  int n_errors = 0;
  int samples_checked = 0;
  // one sample per channel: A=111, B=222, C=333, D=444
  localparam logic [FRM_W-1:0] SMP = 48'h4443_3322_2111;

  cls_config_framer i_cls_config_framer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .frm_valid(frm_valid), .frm_data(frm_data), .frm_ready(frm_ready),
    .chan_en(chan_en), .conv_count(conv_count), .lane_count(lane_count),
    .tail_pad(tail_pad), .sh_crc_sel(sh_crc_sel), .sh_fec_sel(sh_fec_sel), .sh_cmd(sh_cmd));
  cls_rx_model i_cls_rx_model (.clk(clk), .rst_n(rst_n), .slow(slow),
    .frm_valid(frm_valid), .frm_data(frm_data), .frm_ready(frm_ready));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one-cycle write strobe; derived outputs settle two cycles later
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask : rd

  // hold the word until an edge sees ready high
  task automatic push(input logic [FRM_W-1:0] d);
    logic ok;
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_data <= d;
    do begin
      #1;
      ok = smp_ready;
      @(posedge clk);
    end while (!ok);
    smp_valid <= 1'b0;
  endtask : push

  // wait, bounded, until the receiver has n words
  task automatic wait_rx(input int n);
    for (int i = 0; i < 200 && i_cls_rx_model.q.size() < n; i++) @(posedge clk);
    `CHK(i_cls_rx_model.q.size(), n)
  endtask : wait_rx

  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // longest path is the fill and drain, well under 2000 cycles; 20000 is a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // expected derived outputs per enable setting: ce, base lanes, chan, conv, lane, tail
  logic [7:0] t_ce[5] = '{8'h03, 8'h02, 8'h01, 8'h05, 8'h02};
  logic [3:0] t_bl[5] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h8};
  logic [3:0] t_ch[5] = '{4'hf, 4'hc, 4'h3, 4'h1, 4'hc};
  logic [2:0] t_cv[5] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h2};
  logic [3:0] t_ln[5] = '{4'h5, 4'h3, 4'h3, 4'h5, 4'h4};
  logic t_tp[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  // frame slot contents; half modes only fix the two low slots
  logic [FRM_W-1:0] t_fr[5] = '{SMP, 48'h0000_0044_4333, 48'h0000_0022_2111,
    48'h0000_0000_0111, 48'h0000_0044_4333};
  logic [FRM_W-1:0] t_mk[5] = '{'1, 48'h0000_00ff_ffff, 48'h0000_00ff_ffff, '1,
    48'h0000_00ff_ffff};
  logic [7:0] s_lc[3] = '{8'h20, 8'h20, 8'h00};
  logic [7:0] s_sh[3] = '{8'h02, 8'h00, 8'h02};
  logic s_cr[3] = '{1'b0, 1'b1, 1'b0};
  logic s_fe[3] = '{1'b1, 1'b0, 1'b0};

  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, smp_valid, slow} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    smp_data = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK({chan_en, conv_count, lane_count, tail_pad}, {4'hf, 3'h4, 4'h8, 1'b0})
    `CHK({sh_crc_sel, sh_fec_sel, sh_cmd}, 10'h000)
    rd(ADDR_CONV_EN, 8'h03);
    rd(ADDR_SH_CFG, 8'h00);
    rd(10'h3ff, 8'h00);
    // enable settings; link is stopped around every change
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_LINK_CTRL, 8'h00);
      wr(ADDR_LANE_CFG, {4'h0, t_bl[i]});
      wr(ADDR_CONV_EN, t_ce[i]);
      repeat (2) @(posedge clk);
      #1;
      `CHK({chan_en, conv_count, lane_count}, {t_ch[i], t_cv[i], t_ln[i]})
      `CHK(tail_pad, t_tp[i])
      rd(ADDR_CONV_EN, t_ce[i]);
      rd(ADDR_STATUS, {t_tp[i], t_cv[i], t_ln[i]});
      wr(ADDR_LINK_CTRL, 8'h01);
      push(SMP);
      wait_rx(1);
      `CHK(i_cls_rx_model.q[0] & t_mk[i], t_fr[i])
      i_cls_rx_model.q.delete();
    end
    // header select across encodings, changed only with the link off
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_LINK_CTRL, s_lc[i]);
      wr(ADDR_SH_CFG, s_sh[i]);
      repeat (2) @(posedge clk);
      #1;
      `CHK({sh_crc_sel, sh_fec_sel}, {s_cr[i], s_fe[i]})
      `CHK(sh_cmd, 8'h00)
      rd(ADDR_SH_CFG, s_sh[i]);
    end
    // fill the buffer with the link off until it refuses
    wr(ADDR_LINK_CTRL, 8'h00);
    wr(ADDR_CONV_EN, 8'h03);
    for (int i = 0; i < FIFO_DEPTH; i++) push(SMP + 48'(i));
    #1;
    // the output stage holds one word, so one place is still free
    `CHK(smp_ready, 1'b1)
    push(SMP + 48'(FIFO_DEPTH));
    #1;
    `CHK(smp_ready, 1'b0)
    `CHK(i_cls_rx_model.q.size(), 0)
    // drain with a stalling receiver; order must survive
    slow <= 1'b1;
    wr(ADDR_LINK_CTRL, 8'h01);
    wait_rx(FIFO_DEPTH + 1);
    for (int i = 0; i <= FIFO_DEPTH; i++) `CHK(i_cls_rx_model.q[i], SMP + 48'(i))
    #1;
    `CHK(smp_ready, 1'b1)
    give_verdict();
  end
endmodule : converter_lane_enable_sync_header_tb
